// [rtl/mei_params.svh]
`ifndef MEI_PARAMS_SVH
`define MEI_PARAMS_SVH

// System clock.
`define MEI_CLK_PERIOD_NS   100.0

// Transmit flag lead times, before transmission starts.
`define MEI_LEAD_2G_US      50.0
`define MEI_LEAD_3G_MS      22.0
`define MEI_LEAD_LTE_MS     10.5

// Transmit flag lag times, after transmission ends.
`define MEI_LAG_2G_US       60.0
`define MEI_LAG_3G_US       90.0
`define MEI_LAG_LTE_MS      4.0

// Ring pulse width in system clock cycles (100 us at 10 MHz).
`define MEI_RING_PULSE_CYC  1000

// Timer counter width; holds the longest count of 220000 cycles.
`define MEI_TMR_W           18

// Register byte offsets.
`define MEI_OFS_CTRL        12'h000
`define MEI_OFS_EVENT       12'h004
`define MEI_OFS_WAKE_MASK   12'h008
`define MEI_OFS_STATUS      12'h00C

// Control register fields.
`define MEI_CTRL_TX_GO      0
`define MEI_CTRL_RAT_LO     1
`define MEI_CTRL_RAT_HI     2
`define MEI_CTRL_LAMP_ON    3
`define MEI_CTRL_PWR_SAFE   4
`define MEI_CTRL_W          5
`define MEI_CTRL_RESET      5'h00

// Event register and wake mask fields: voice call, data call, timer, short message.
`define MEI_EVT_W           4
`define MEI_WAKE_MASK_RESET 4'h0

// Status register fields.
`define MEI_ST_CARD         0
`define MEI_ST_TX_FLAG      1
`define MEI_ST_TX_GATE      2
`define MEI_ST_WAKE         3
`define MEI_ST_RING         4

`endif

// [rtl/mei_pkg.sv]
package mei_pkg;

  typedef enum logic [3:0] {
    MEI_TX_IDLE = 4'h1,
    MEI_TX_LEAD = 4'h2,
    MEI_TX_ON   = 4'h4,
    MEI_TX_LAG  = 4'h8
  } mei_tx_state_t;

  typedef enum logic [1:0] {
    MEI_RAT_2G  = 2'h0,
    MEI_RAT_3G  = 2'h1,
    MEI_RAT_LTE = 2'h2
  } mei_rat_t;

endpackage : mei_pkg

// [rtl/mei_timer.sv]
`timescale 1ns/10ps
`default_nettype none
`include "mei_params.svh"

module mei_timer #(
  parameter int W = `MEI_TMR_W
) (
  // Clock and reset.
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control.
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // Status.
  output logic              expired
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  always_comb begin
    count_nxt = count_r;
    if (load) begin
      count_nxt = load_val;
    end else if (count_r != '0) begin
      count_nxt = count_r - W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign expired = (count_r == '0) && !load;

endmodule // mei_timer

`default_nettype wire

// [rtl/mei_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "mei_params.svh"

module mei_top
  import mei_pkg::*;
#(
  parameter int LEAD_2G_CYC  = int'($ceil(`MEI_LEAD_2G_US * 1000.0 / `MEI_CLK_PERIOD_NS)),
  parameter int LEAD_3G_CYC  = int'($ceil(`MEI_LEAD_3G_MS * 1000000.0 / `MEI_CLK_PERIOD_NS)),
  parameter int LEAD_LTE_CYC = int'($ceil(`MEI_LEAD_LTE_MS * 1000000.0 / `MEI_CLK_PERIOD_NS)),
  parameter int LAG_2G_CYC   = int'($ceil(`MEI_LAG_2G_US * 1000.0 / `MEI_CLK_PERIOD_NS)),
  parameter int LAG_3G_CYC   = int'($ceil(`MEI_LAG_3G_US * 1000.0 / `MEI_CLK_PERIOD_NS)),
  parameter int LAG_LTE_CYC  = int'($ceil(`MEI_LAG_LTE_MS * 1000000.0 / `MEI_CLK_PERIOD_NS)),
  parameter int RING_CYC     = `MEI_RING_PULSE_CYC
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Indication pins.
  output logic             tx_active_flag,
  output logic             tx_gate_out,
  output logic             status_lamp_drive_n_o,
  output logic             status_lamp_drive_n_oe,
  output logic             host_wake_out,
  output logic             ring_event_out,
  output logic             power_off_safe,
  input  wire logic        card_present_in
);

  localparam int TW = `MEI_TMR_W;

  function automatic logic [TW-1:0] lead_cycles(input logic [1:0] rat);
    case (rat)
      MEI_RAT_3G:  lead_cycles = TW'(LEAD_3G_CYC);
      MEI_RAT_LTE: lead_cycles = TW'(LEAD_LTE_CYC);
      default:     lead_cycles = TW'(LEAD_2G_CYC);
    endcase
  endfunction

  function automatic logic [TW-1:0] lag_cycles(input logic [1:0] rat);
    case (rat)
      MEI_RAT_3G:  lag_cycles = TW'(LAG_3G_CYC);
      MEI_RAT_LTE: lag_cycles = TW'(LAG_LTE_CYC);
      default:     lag_cycles = TW'(LAG_2G_CYC);
    endcase
  endfunction

  // Bus slave and register file.
  logic [`MEI_CTRL_W-1:0] ctrl_r,      ctrl_nxt;
  logic [`MEI_EVT_W-1:0]  wmask_r,     wmask_nxt;
  logic [31:0]            prdata_r,    prdata_nxt;
  logic                   pready_r,    pready_nxt;
  logic                   pslverr_r,   pslverr_nxt;
  logic                   card_r;
  logic                   wake_r,      wake_nxt;
  logic [`MEI_EVT_W-1:0]  evt_wr;
  logic                   wake_clr;
  logic                   acc_done;
  logic                   mapped;
  logic [31:0]            rd_val;

  // Transmit sequencer and ring pulse.
  mei_tx_state_t          tx_st_r,     tx_st_nxt;
  logic [1:0]             rat_r,       rat_nxt;
  logic                   flag_r,      flag_nxt;
  logic                   gate_r,      gate_nxt;
  logic                   tmr_load;
  logic [TW-1:0]          tmr_val;
  logic                   tmr_exp;
  logic [TW-1:0]          ring_cnt_r,  ring_cnt_nxt;
  logic                   ring_r,      ring_nxt;

  // A write lands only at the edge where the slave shows pready high.
  assign acc_done = psel && penable && pready_r;
  assign mapped   = (paddr == `MEI_OFS_CTRL) || (paddr == `MEI_OFS_EVENT) ||
                    (paddr == `MEI_OFS_WAKE_MASK) || (paddr == `MEI_OFS_STATUS);
  assign evt_wr   = (acc_done && pwrite && paddr == `MEI_OFS_EVENT) ? pwdata[`MEI_EVT_W-1:0] : '0;
  assign wake_clr = acc_done && pwrite && paddr == `MEI_OFS_STATUS && pwdata[`MEI_ST_WAKE];

  always_comb begin
    rd_val = '0;
    case (paddr)
      `MEI_OFS_CTRL:      rd_val[`MEI_CTRL_W-1:0] = ctrl_r;
      `MEI_OFS_WAKE_MASK: rd_val[`MEI_EVT_W-1:0]  = wmask_r;
      `MEI_OFS_STATUS: begin
        rd_val[`MEI_ST_CARD]    = card_r;
        rd_val[`MEI_ST_TX_FLAG] = flag_r;
        rd_val[`MEI_ST_TX_GATE] = gate_r;
        rd_val[`MEI_ST_WAKE]    = wake_r;
        rd_val[`MEI_ST_RING]    = ring_r;
      end
      default:            rd_val = '0;
    endcase
  end

  always_comb begin
    ctrl_nxt    = ctrl_r;
    wmask_nxt   = wmask_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    pready_nxt  = 1'b0;
    // One wait state gives time to register read data and the error answer.
    if (psel && penable && !pready_r) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !mapped;
      prdata_nxt  = (pwrite || !mapped) ? 32'h0000_0000 : rd_val;
    end
    if (acc_done && pwrite && paddr == `MEI_OFS_CTRL) begin
      ctrl_nxt = pwdata[`MEI_CTRL_W-1:0];
    end
    if (acc_done && pwrite && paddr == `MEI_OFS_WAKE_MASK) begin
      wmask_nxt = pwdata[`MEI_EVT_W-1:0];
    end
    // Set wins over a clear that lands in the same cycle.
    wake_nxt = wake_r;
    if (wake_clr) begin
      wake_nxt = 1'b0;
    end
    if ((evt_wr & wmask_r) != '0) begin
      wake_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= `MEI_CTRL_RESET;
      wmask_r   <= `MEI_WAKE_MASK_RESET;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      wake_r    <= 1'b0;
      card_r    <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      wmask_r   <= wmask_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      wake_r    <= wake_nxt;
      card_r    <= card_present_in;
    end
  end

  // Transmit sequencer. The technology is latched when a lead starts so that a
  // change mid-burst cannot shorten a lead or lag already running.
  always_comb begin
    tx_st_nxt = tx_st_r;
    rat_nxt   = rat_r;
    flag_nxt  = flag_r;
    gate_nxt  = gate_r;
    tmr_load  = 1'b0;
    tmr_val   = '0;
    case (tx_st_r)
      MEI_TX_IDLE: begin
        if (ctrl_r[`MEI_CTRL_TX_GO]) begin
          rat_nxt   = ctrl_r[`MEI_CTRL_RAT_HI:`MEI_CTRL_RAT_LO];
          tmr_load  = 1'b1;
          tmr_val   = lead_cycles(ctrl_r[`MEI_CTRL_RAT_HI:`MEI_CTRL_RAT_LO]);
          flag_nxt  = 1'b1;
          tx_st_nxt = MEI_TX_LEAD;
        end
      end
      MEI_TX_LEAD: begin
        if (!ctrl_r[`MEI_CTRL_TX_GO]) begin
          tmr_load  = 1'b1;
          tmr_val   = lag_cycles(rat_r);
          tx_st_nxt = MEI_TX_LAG;
        end else if (tmr_exp) begin
          gate_nxt  = 1'b1;
          tx_st_nxt = MEI_TX_ON;
        end
      end
      MEI_TX_ON: begin
        if (!ctrl_r[`MEI_CTRL_TX_GO]) begin
          gate_nxt  = 1'b0;
          tmr_load  = 1'b1;
          tmr_val   = lag_cycles(rat_r);
          tx_st_nxt = MEI_TX_LAG;
        end
      end
      MEI_TX_LAG: begin
        // A new request during the lag restarts the full lead; the flag stays high.
        if (ctrl_r[`MEI_CTRL_TX_GO]) begin
          rat_nxt   = ctrl_r[`MEI_CTRL_RAT_HI:`MEI_CTRL_RAT_LO];
          tmr_load  = 1'b1;
          tmr_val   = lead_cycles(ctrl_r[`MEI_CTRL_RAT_HI:`MEI_CTRL_RAT_LO]);
          tx_st_nxt = MEI_TX_LEAD;
        end else if (tmr_exp) begin
          flag_nxt  = 1'b0;
          tx_st_nxt = MEI_TX_IDLE;
        end
      end
      default: begin
        flag_nxt  = 1'b0;
        gate_nxt  = 1'b0;
        tx_st_nxt = MEI_TX_IDLE;
      end
    endcase
  end

  // Ring pulse: a new event while the pulse runs is absorbed, not extended.
  always_comb begin
    ring_cnt_nxt = ring_cnt_r;
    ring_nxt     = ring_r;
    if (ring_r) begin
      if (ring_cnt_r == TW'(1)) begin
        ring_nxt = 1'b0;
      end
      ring_cnt_nxt = ring_cnt_r - TW'(1);
    end else if (evt_wr != '0) begin
      ring_nxt     = 1'b1;
      ring_cnt_nxt = TW'(RING_CYC);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r    <= MEI_TX_IDLE;
      rat_r      <= MEI_RAT_2G;
      flag_r     <= 1'b0;
      gate_r     <= 1'b0;
      ring_cnt_r <= '0;
      ring_r     <= 1'b0;
    end else begin
      tx_st_r    <= tx_st_nxt;
      rat_r      <= rat_nxt;
      flag_r     <= flag_nxt;
      gate_r     <= gate_nxt;
      ring_cnt_r <= ring_cnt_nxt;
      ring_r     <= ring_nxt;
    end
  end

  mei_timer #(
    .W        (TW)
  ) u_tmr (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_exp)
  );

  // Lamp and safe-power pins are registered so every output leaves a flop.
  logic lamp_oe_r;
  logic pwr_safe_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_oe_r  <= 1'b0;
      pwr_safe_r <= 1'b0;
    end else begin
      lamp_oe_r  <= ctrl_r[`MEI_CTRL_LAMP_ON];
      pwr_safe_r <= ctrl_r[`MEI_CTRL_PWR_SAFE];
    end
  end

  // The lamp pin data is a constant-low flop; only the enable moves.
  logic lamp_lvl_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_lvl_r <= 1'b0;
    end else begin
      lamp_lvl_r <= 1'b0;
    end
  end

  assign prdata                 = prdata_r;
  assign pready                 = pready_r;
  assign pslverr                = pslverr_r;
  assign tx_active_flag         = flag_r;
  assign tx_gate_out            = gate_r;
  assign status_lamp_drive_n_o  = lamp_lvl_r;
  assign status_lamp_drive_n_oe = lamp_oe_r;
  assign host_wake_out          = wake_r;
  assign ring_event_out         = ring_r;
  assign power_off_safe         = pwr_safe_r;

endmodule // mei_top

`default_nettype wire

// [tb/mei_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module mei_host_model (
  // Board side of the pins.
  input  wire logic pclk,
  input  wire logic status_lamp_drive_n_o,
  input  wire logic status_lamp_drive_n_oe,
  input  wire logic ring_event_out,
  input  wire logic card_fit,
  output logic      lamp_wire,
  output logic      card_present_in,
  output int        rings = 0
);
  logic ring_q = 1'b0;
  // The lamp line has a pull-up, so a released pin reads high.
  assign lamp_wire = status_lamp_drive_n_oe ? status_lamp_drive_n_o : 1'b1;
  assign card_present_in = card_fit;
  always @(posedge pclk) begin
    if (ring_event_out && !ring_q) begin
      rings <= rings + 1;
    end
    ring_q <= ring_event_out;
  end
endmodule // mei_host_model
`default_nettype wire

// [tb/mei_props_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module mei_props #(
  parameter int LEAD_2G_CYC = 6
) (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins.
  input wire logic        tx_active_flag,
  input wire logic        tx_gate_out,
  input wire logic        status_lamp_drive_n_o,
  input wire logic        host_wake_out,
  input wire logic        ring_event_out
);
  logic [15:0] lead_r;
  logic [15:0] lead_nxt;
  logic        evt_wr;
  logic        clr_wr;
  assign evt_wr = pready && pwrite && paddr == 12'h004 && pwdata[3:0] != 4'h0;
  assign clr_wr = pready && pwrite && paddr == 12'h00C && pwdata[3];
  // Counting flag-only cycles lets the lead be judged at the moment the gate opens.
  always_comb begin
    lead_nxt = (tx_active_flag && !tx_gate_out) ? lead_r + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lead_r <= 16'h0000;
    end else begin
      lead_r <= lead_nxt;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pulse;
    ring_event_out [*5] ##1 !ring_event_out;
  endsequence
  a_lamp_never_high: assert property (status_lamp_drive_n_o == 1'b0)
    else $error("lamp data high");
  a_gate_in_flag: assert property (tx_gate_out |-> tx_active_flag)
    else $error("gate without flag");
  a_lead_time: assert property ($rose(tx_gate_out) |-> lead_r >= LEAD_2G_CYC)
    else $error("lead too short");
  a_lag_time: assert property ($fell(tx_gate_out) |-> tx_active_flag [*4])
    else $error("lag too short");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_map: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr[11:4] != 8'h00))
    else $error("pslverr wrong");
  a_ring_width: assert property ($rose(ring_event_out) |-> s_pulse)
    else $error("ring width wrong");
  a_ring_cause: assert property ($rose(ring_event_out) |-> $past(evt_wr) || $past(evt_wr, 2))
    else $error("ring without event");
  a_wake_hold: assert property (host_wake_out && !clr_wr |=> host_wake_out)
    else $error("wake dropped");
endmodule // mei_props

bind mei_top mei_props #(.LEAD_2G_CYC(LEAD_2G_CYC)) u_mei_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .tx_active_flag, .tx_gate_out, .status_lamp_drive_n_o,
  .host_wake_out, .ring_event_out);
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int LEAD [3] = '{6, 12, 9};
  localparam int LAG [3] = '{600, 900, 10};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        card_fit = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic        err;
  logic        pready, pslverr, tx_active_flag, tx_gate_out, status_lamp_drive_n_o;
  logic        status_lamp_drive_n_oe, host_wake_out, ring_event_out, power_off_safe;
  logic        card_present_in, lamp_wire;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          rings, n, i;

  // The 2G and 3G lags keep their full lengths, which are short enough to run as they are.
  mei_top #(.LEAD_2G_CYC(6), .LEAD_3G_CYC(12), .LEAD_LTE_CYC(9),
    .LAG_LTE_CYC(10), .RING_CYC(5)) u_mei_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tx_active_flag, .tx_gate_out, .status_lamp_drive_n_o,
    .status_lamp_drive_n_oe, .host_wake_out, .ring_event_out, .power_off_safe, .card_present_in);
  mei_host_model u_mei_host_model (.pclk, .status_lamp_drive_n_o, .status_lamp_drive_n_oe,
    .ring_event_out, .card_fit, .lamp_wire, .card_present_in, .rings);

  initial forever #50 pclk = ~pclk;

  task complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The request stays put until pready is seen high at a rising edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  task wait_for(input bit flag, input logic v, input int lim, output int k);
    k = 0;
    while ((flag ? tx_active_flag : tx_gate_out) !== v && k < lim) begin
      @(posedge pclk);
      k++;
    end
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h008, 32'h0);
    rd(12'h00C, 32'h0);
    chk(power_off_safe, 1'b0);
    chk(lamp_wire, 1'b1);
    rd(12'h010, 32'h0);
    chk(err, 1'b1);
    card_fit <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(12'h00C, 32'h1);
    wr(12'h000, 32'h8);
    repeat (2) @(posedge pclk);
    chk(lamp_wire, 1'b0);
    wr(12'h000, 32'h10);
    repeat (2) @(posedge pclk);
    chk(lamp_wire, 1'b1);
    chk(power_off_safe, 1'b1);
    wr(12'h008, 32'h1);
    for (i = 0; i < 4; i++) begin
      n = rings;
      wr(12'h004, 32'h1 << i);
      repeat (8) @(posedge pclk);
      chk(rings - n, 1);
      chk(host_wake_out, i == 0);
      wr(12'h00C, 32'h8);
    end
    n = rings;
    wr(12'h004, 32'h1);
    wr(12'h004, 32'h2);
    repeat (10) @(posedge pclk);
    chk(rings - n, 1);
    wr(12'h000, 32'h0);
    for (i = 0; i < 3; i++) begin
      wr(12'h000, 32'h1 | (i << 1));
      wait_for(1'b0, 1'b1, 100, n);
      chk(n >= LEAD[i], 1'b1);
      chk(n <= LEAD[i] + 4, 1'b1);
      chk(tx_gate_out, 1'b1);
      chk(tx_active_flag, 1'b1);
      wr(12'h000, i << 1);
      wait_for(1'b1, 1'b0, 1000, n);
      chk(n >= LAG[i], 1'b1);
      chk(n <= LAG[i] + 4, 1'b1);
      chk(tx_active_flag, 1'b0);
      chk(tx_gate_out, 1'b0);
    end
    // A request dropped during the lead must never open the gate.
    wr(12'h000, 32'h5);
    wr(12'h000, 32'h4);
    wait_for(1'b0, 1'b1, 40, n);
    chk(n, 40);
    chk(tx_active_flag, 1'b0);
    complete_run();
  end
endmodule // tb
`default_nettype wire
